//--- logic/cpmu_consts.svh
`ifndef CPMU_CONSTS_SVH
`define CPMU_CONSTS_SVH
`define CPMU_ADDR_W        8
`define CPMU_OFF_REG_CTRL  8'h00
`define CPMU_OFF_IO_CTRL   8'h04
`define CPMU_OFF_OSC_CTRL  8'h08
`define CPMU_OFF_DUTY      8'h0C
`define CPMU_OFF_ISINK     8'h10
`define CPMU_OFF_STATUS    8'h14
`define CPMU_B_EN1         0
`define CPMU_B_EN2         1
`define CPMU_B_PG1         2
`define CPMU_B_PG2         3
`define CPMU_B_GPO_LVL     0
`define CPMU_B_GPO_OD      1
`define CPMU_B_GPIO_LVL    3
`define CPMU_B_GPIO_DIR    4
`define CPMU_B_GPIO_OD     5
`define CPMU_B_CLK_EN      2
`define CPMU_B_DIM_LO      4
`define CPMU_B_THERM       4
`define CPMU_IO_RST        6'h00
`define CPMU_DUTY_RST      10'h000
`define CPMU_ISINK_RST     8'h00
`define CPMU_STARTUP_CYC   131072
`define CPMU_DLY_W         18
`define CPMU_PRE_BASE      6'h04
`define CPMU_RESP_OKAY     2'h0
`define CPMU_RESP_SLVERR   2'h2
`endif

//--- logic/cpmu_pkg.sv
`include "cpmu_consts.svh"
package cpmu_pkg;
  // Dimming generator states.
  typedef enum logic [1:0] {
    CPMU_PWM_IDLE = 2'b01,
    CPMU_PWM_RUN  = 2'b10
  } cpmu_pwm_e;

  // All state of the control block.
  typedef struct packed {
    logic                   en1;
    logic                   en2;
    logic [5:0]             io;
    logic [1:0]             oscillator_frequency_select;
    logic                   clk_en_bit;
    logic [1:0]             dim_freq;
    logic [9:0]             duty;
    logic [7:0]             isink;
    logic                   therm_flag;
    logic                   aw_got;
    logic [7:0]             aw_addr;
    logic                   w_got;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic [`CPMU_DLY_W-1:0] dly_cnt;
    logic                   clk_ready;
    cpmu_pwm_e              pwm_st;
    logic [5:0]             pre_cnt;
    logic [7:0]             step;
    logic [1:0]             grp;
    logic                   gpo_o;
    logic                   gpo_oe;
    logic                   gpio_o;
    logic                   gpio_oe;
    logic                   reg1_en;
    logic                   reg2_en;
    logic                   dis1;
    logic                   dis2;
    logic                   osc_en;
    logic                   sclk_en;
    logic                   led_pwm;
    logic                   sink_en;
    logic [7:0]             sink_code;
  } cpmu_state_s;
endpackage : cpmu_pkg

//--- logic/cpmu_top.sv
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "cpmu_consts.svh"
module cpmu_top
  import cpmu_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = `CPMU_STARTUP_CYC
) (
  input  wire logic        aclk,                     // System clock, 200 MHz.
  input  wire logic        aresetn,                  // Sync reset, low during lockout.
  input  wire logic [7:0]  s_axi_awaddr,             // Write address.
  input  wire logic        s_axi_awvalid,            // Write address valid.
  output logic             s_axi_awready,            // Write address ready.
  input  wire logic [31:0] s_axi_wdata,              // Write data.
  input  wire logic [3:0]  s_axi_wstrb,              // Write byte strobes.
  input  wire logic        s_axi_wvalid,             // Write data valid.
  output logic             s_axi_wready,             // Write data ready.
  output logic [1:0]       s_axi_bresp,              // Write response.
  output logic             s_axi_bvalid,             // Write response valid.
  input  wire logic        s_axi_bready,             // Write response ready.
  input  wire logic [7:0]  s_axi_araddr,             // Read address.
  input  wire logic        s_axi_arvalid,            // Read address valid.
  output logic             s_axi_arready,            // Read address ready.
  output logic [31:0]      s_axi_rdata,              // Read data.
  output logic [1:0]       s_axi_rresp,              // Read response.
  output logic             s_axi_rvalid,             // Read data valid.
  input  wire logic        s_axi_rready,             // Read data ready.
  input  wire logic        thermal_event,            // Thermal shutdown, high active.
  input  wire logic        first_regulator_pg_in,    // First regulator comparator.
  input  wire logic        second_regulator_pg_in,   // Second regulator comparator.
  input  wire logic        privacy_led_enable_pin,   // Privacy LED enable pin.
  input  wire logic        osc_stable,               // Oscillator is stable.
  input  wire logic        osc_tick,                 // One pulse per oscillator cycle.
  input  wire logic        gpio_in,                  // General io pin level.
  output logic             gpio_out,                 // General io pin drive level.
  output logic             gpio_oe,                  // General io pin drive enable.
  output logic             general_output_pin_out,   // General output drive level.
  output logic             general_output_pin_oe,    // General output drive enable.
  output logic             first_regulator_en,       // First regulator enable.
  output logic             second_regulator_en,      // Second regulator enable.
  output logic             first_regulator_dis,      // First output discharge on.
  output logic             second_regulator_dis,     // Second output discharge on.
  output logic             osc_enable,               // Crystal oscillator run.
  output logic             sensor_clock_output_en,   // Sensor clock buffer enable.
  output logic             led_sink_en,              // LED current sink active.
  output logic [7:0]       led_sink_code,            // LED current setting applied.
  output logic             led_pwm                   // Dimming gate for the sink.
);

  cpmu_state_s s_reg;
  cpmu_state_s s_next;

  logic [31:0] wmask;
  logic        wr_fire;
  logic        rd_fire;
  logic        stat_pg1;
  logic        stat_pg2;
  logic        pwm_hi;
  logic        period_end;
  logic [5:0]  pre_term;
  logic [8:0]  thresh;

  // Merges the strobed byte lanes of a write into an old register value.
  function automatic logic [31:0] cpmu_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [31:0] mask);
    cpmu_merge = (old_v & ~mask) | (new_v & mask);
  endfunction : cpmu_merge

  // Bus handshake signals come straight from the state.
  assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
  assign s_axi_wready  = !s_reg.w_got && !s_reg.bvalid;
  assign s_axi_bvalid  = s_reg.bvalid;
  assign s_axi_bresp   = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid  = s_reg.rvalid;
  assign s_axi_rdata   = s_reg.rdata;
  assign s_axi_rresp   = s_reg.rresp;

  // Pin and control outputs, all taken from flip-flops.
  assign gpio_out               = s_reg.gpio_o;
  assign gpio_oe                = s_reg.gpio_oe;
  assign general_output_pin_out = s_reg.gpo_o;
  assign general_output_pin_oe  = s_reg.gpo_oe;
  assign first_regulator_en     = s_reg.reg1_en;
  assign second_regulator_en    = s_reg.reg2_en;
  assign first_regulator_dis    = s_reg.dis1;
  assign second_regulator_dis   = s_reg.dis2;
  assign osc_enable             = s_reg.osc_en;
  assign sensor_clock_output_en = s_reg.sclk_en;
  assign led_sink_en            = s_reg.sink_en;
  assign led_sink_code          = s_reg.sink_code;
  assign led_pwm                = s_reg.led_pwm;

  // Power-good reads high only for an enabled regulator in regulation.
  assign stat_pg1 = s_reg.reg1_en && first_regulator_pg_in;
  assign stat_pg2 = s_reg.reg2_en && second_regulator_pg_in;

  // Dimming period: 256 steps, each step 4, 8, 16 or 32 oscillator cycles.
  assign pre_term   = (`CPMU_PRE_BASE << s_reg.dim_freq) - 6'h01;
  assign period_end = osc_tick && s_reg.pre_cnt == pre_term && s_reg.step == 8'hFF;
  // Pulse width is the upper duty bits plus one step on dithered periods.
  assign thresh = {1'b0, s_reg.duty[9:2]}
                + {8'h00, (s_reg.grp < s_reg.duty[1:0])};
  assign pwm_hi = {1'b0, s_reg.step} < thresh;

  // Write and read strobes: both write halves held, or a read accepted.
  assign wr_fire = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
  assign rd_fire = s_axi_arvalid && !s_reg.rvalid;
  assign wmask   = {{8{s_reg.w_strb[3]}}, {8{s_reg.w_strb[2]}},
                    {8{s_reg.w_strb[1]}}, {8{s_reg.w_strb[0]}}};

  // Next state of registers, bus slave, start-up counter and dimming.
  always_comb begin
    logic [31:0] tmp;
    tmp    = 32'h0000_0000;
    s_next = s_reg;

    // Capture write address and data in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      s_next.aw_got  = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.w_got  = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end

    // Register write decode.
    if (wr_fire) begin
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = `CPMU_RESP_OKAY;
      if (s_reg.aw_addr == `CPMU_OFF_REG_CTRL) begin
        tmp = cpmu_merge({30'h0, s_reg.en2, s_reg.en1}, s_reg.w_data, wmask);
        s_next.en1 = tmp[`CPMU_B_EN1];
        s_next.en2 = tmp[`CPMU_B_EN2];
      end else if (s_reg.aw_addr == `CPMU_OFF_IO_CTRL) begin
        tmp = cpmu_merge({26'h0, s_reg.io}, s_reg.w_data, wmask);
        s_next.io = {tmp[5:3], 1'b0, tmp[1:0]};
      end else if (s_reg.aw_addr == `CPMU_OFF_OSC_CTRL) begin
        tmp = cpmu_merge({26'h0, s_reg.dim_freq, 1'b0, s_reg.clk_en_bit, s_reg.oscillator_frequency_select},
                         s_reg.w_data, wmask);
        s_next.oscillator_frequency_select   = tmp[1:0];
        s_next.clk_en_bit = tmp[`CPMU_B_CLK_EN];
        s_next.dim_freq   = tmp[`CPMU_B_DIM_LO+1:`CPMU_B_DIM_LO];
      end else if (s_reg.aw_addr == `CPMU_OFF_DUTY) begin
        tmp = cpmu_merge({22'h0, s_reg.duty}, s_reg.w_data, wmask);
        s_next.duty = tmp[9:0];
      end else if (s_reg.aw_addr == `CPMU_OFF_ISINK) begin
        tmp = cpmu_merge({24'h0, s_reg.isink}, s_reg.w_data, wmask);
        s_next.isink = tmp[7:0];
      end else if (s_reg.aw_addr == `CPMU_OFF_STATUS) begin
        if (s_reg.w_strb[0] && s_reg.w_data[`CPMU_B_THERM]) begin
          s_next.therm_flag = 1'b0;
        end
      end else begin
        s_next.bresp = `CPMU_RESP_SLVERR;
      end
    end

    // Register read decode; unmapped words read zero with an error.
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (rd_fire) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = `CPMU_RESP_OKAY;
      s_next.rdata  = 32'h0000_0000;
      if (s_axi_araddr == `CPMU_OFF_REG_CTRL) begin
        s_next.rdata[3:0] = {stat_pg2, stat_pg1, s_reg.en2, s_reg.en1};
      end else if (s_axi_araddr == `CPMU_OFF_IO_CTRL) begin
        s_next.rdata[5:0] = s_reg.io;
      end else if (s_axi_araddr == `CPMU_OFF_OSC_CTRL) begin
        s_next.rdata[5:0] = {s_reg.dim_freq, 1'b0, s_reg.clk_en_bit, s_reg.oscillator_frequency_select};
      end else if (s_axi_araddr == `CPMU_OFF_DUTY) begin
        s_next.rdata[9:0] = s_reg.duty;
      end else if (s_axi_araddr == `CPMU_OFF_ISINK) begin
        s_next.rdata[7:0] = s_reg.isink;
      end else if (s_axi_araddr == `CPMU_OFF_STATUS) begin
        s_next.rdata[4:0] = {s_reg.therm_flag, s_reg.pwm_st == CPMU_PWM_RUN,
                             s_reg.sclk_en, s_reg.clk_ready, s_reg.osc_en};
      end else begin
        s_next.rresp = `CPMU_RESP_SLVERR;
      end
    end

    // Thermal event overrides a same-cycle write to the enables or the flag; flag set wins.
    if (thermal_event) begin
      s_next.en1        = 1'b0;
      s_next.en2        = 1'b0;
      s_next.therm_flag = 1'b1;
    end

    // The io level bit is held low while its buffer has no supply.
    if (!s_next.en1) begin
      s_next.io[`CPMU_B_GPIO_LVL] = 1'b0;
    end

    // Start-up delay counts oscillator cycles once stable.
    if (!s_reg.clk_en_bit || !s_reg.osc_en || !osc_stable) begin
      s_next.dly_cnt   = '0;
      s_next.clk_ready = 1'b0;
    end else if (!s_reg.clk_ready && osc_tick) begin
      if (s_reg.dly_cnt == `CPMU_DLY_W'(STARTUP_CYCLES - 1)) begin
        s_next.clk_ready = 1'b1;
      end else begin
        s_next.dly_cnt = s_reg.dly_cnt + `CPMU_DLY_W'(1);
      end
    end

    // Dimming generator: starts at a period boundary, stops only at one.
    case (s_reg.pwm_st)
      CPMU_PWM_IDLE: begin
        s_next.pre_cnt = 6'h00;
        s_next.step    = 8'h00;
        s_next.grp     = 2'h0;
        if (privacy_led_enable_pin) begin
          s_next.pwm_st = CPMU_PWM_RUN;
        end
      end
      CPMU_PWM_RUN: begin
        if (osc_tick) begin
          if (s_reg.pre_cnt == pre_term) begin
            s_next.pre_cnt = 6'h00;
            s_next.step    = s_reg.step + 8'h01;
            if (s_reg.step == 8'hFF) begin
              s_next.grp = s_reg.grp + 2'h1;
            end
          end else begin
            s_next.pre_cnt = s_reg.pre_cnt + 6'h01;
          end
        end
        if (period_end && !privacy_led_enable_pin) begin
          s_next.pwm_st = CPMU_PWM_IDLE;
        end
      end
      default: begin
        s_next.pwm_st = CPMU_PWM_IDLE;
      end
    endcase

    // Registered pin and analog control outputs.
    s_next.reg1_en = s_reg.en1;
    s_next.reg2_en = s_reg.en2
                   || (s_reg.en1 && !s_reg.io[`CPMU_B_GPIO_DIR] && gpio_in);
    s_next.dis1    = !s_reg.en1;
    s_next.dis2    = !s_next.reg2_en;
    s_next.gpo_oe  = s_reg.en1
                   && (!s_reg.io[`CPMU_B_GPO_OD] || !s_reg.io[`CPMU_B_GPO_LVL]);
    s_next.gpo_o   = s_reg.en1 && !s_reg.io[`CPMU_B_GPO_OD]
                   && s_reg.io[`CPMU_B_GPO_LVL];
    s_next.gpio_oe = s_reg.en1 && s_reg.io[`CPMU_B_GPIO_DIR]
                   && (!s_reg.io[`CPMU_B_GPIO_OD] || !s_reg.io[`CPMU_B_GPIO_LVL]);
    s_next.gpio_o  = s_reg.en1 && s_reg.io[`CPMU_B_GPIO_DIR] && !s_reg.io[`CPMU_B_GPIO_OD]
                   && s_reg.io[`CPMU_B_GPIO_LVL];
    s_next.osc_en  = s_reg.clk_en_bit || privacy_led_enable_pin;
    s_next.sclk_en = s_reg.clk_en_bit && s_reg.clk_ready && s_reg.en1;
    s_next.sink_en = privacy_led_enable_pin;
    s_next.sink_code = privacy_led_enable_pin ? s_reg.isink : 8'h00;
    s_next.led_pwm = (s_reg.pwm_st == CPMU_PWM_RUN) && pwm_hi;
  end

  // State register; reset models undervoltage lockout.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg            <= '0;
      s_reg.io         <= `CPMU_IO_RST;
      s_reg.duty       <= `CPMU_DUTY_RST;
      s_reg.isink      <= `CPMU_ISINK_RST;
      s_reg.pwm_st     <= CPMU_PWM_IDLE;
      s_reg.dis1       <= 1'b1;
      s_reg.dis2       <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Checks of the control behaviour.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_GPO_PUSHPULL: assert property ((s_reg.en1 && !s_reg.io[1]) |=>
    (general_output_pin_oe && general_output_pin_out == $past(s_reg.io[0])))
    else $error("General output does not follow its level bit.");
  AST_IO_NEEDS_REG1: assert property ((gpio_oe || general_output_pin_oe) |->
    first_regulator_en)
    else $error("Io driven without first regulator.");
  AST_REG2_BY_PIN: assert property ((s_reg.en1 && !s_reg.io[4] && gpio_in) |=>
    second_regulator_en)
    else $error("Input pin did not enable second regulator.");
  AST_GPIO_OUT: assert property ((s_reg.en1 && s_reg.io[4] && !s_reg.io[5]) |=>
    (gpio_oe && gpio_out == $past(s_reg.io[3])))
    else $error("General io output wrong.");
  AST_SINK_PIN: assert property (privacy_led_enable_pin |=> led_sink_en
    && led_sink_code == $past(s_reg.isink))
    else $error("Sink does not follow the enable pin.");
  AST_OSC_RUN: assert property ((s_reg.clk_en_bit || privacy_led_enable_pin) |=>
    osc_enable)
    else $error("Oscillator not running.");
  AST_SCLK_GATE: assert property (sensor_clock_output_en |->
    $past(s_reg.en1 && s_reg.clk_ready && s_reg.clk_en_bit))
    else $error("Sensor clock enabled without its conditions.");
  AST_STARTUP_COUNT: assert property ($rose(s_reg.clk_ready) |->
    $past(s_reg.dly_cnt) == `CPMU_DLY_W'(STARTUP_CYCLES - 1) && $past(osc_tick))
    else $error("Start-up count wrong.");
  AST_THERMAL: assert property (thermal_event |=> (!s_reg.en1 && !s_reg.en2)
    ##1 !first_regulator_en)
    else $error("Thermal event did not clear enables.");
  AST_LVL_LOW: assert property (!s_reg.en1 |-> !s_reg.io[3])
    else $error("Io level bit set without first regulator.");
  AST_DLY_CLEAR: assert property (!s_reg.clk_en_bit |=>
    (s_reg.dly_cnt == '0 && !s_reg.clk_ready))
    else $error("Start-up counter not cleared.");
  AST_PWM_ZERO: assert property (($past(s_reg.duty) == 10'h000) |-> !led_pwm)
    else $error("Zero duty produced a pulse.");
  AST_PWM_STOP: assert property ((s_reg.pwm_st == CPMU_PWM_RUN && !period_end) |=>
    s_reg.pwm_st == CPMU_PWM_RUN)
    else $error("Dimming stopped inside a period.");

  CVR_CLK_READY: cover property ($rose(s_reg.clk_ready));
  CVR_PWM_RUN:   cover property (s_reg.pwm_st == CPMU_PWM_RUN && led_pwm);
  CVR_THERMAL:   cover property (thermal_event && s_reg.en1);
  CVR_WRITE:     cover property (s_axi_bvalid && s_axi_bready);

endmodule : cpmu_top

//--- tb/cpmu_far_model.sv
`timescale 1ns/1ps
// Stand-in for the analog side: crystal, regulator comparators and the io pin wire.
module cpmu_far_model (
  input  wire logic aclk,                   // System clock.
  input  wire logic osc_enable,             // Oscillator run request.
  input  wire logic first_regulator_en,     // First regulator enable.
  input  wire logic second_regulator_en,    // Second regulator enable.
  input  wire logic gpio_out,               // Io pin drive level.
  input  wire logic gpio_oe,                // Io pin drive enable.
  input  wire logic ext_lvl,                // Level from the outside device.
  output logic      osc_stable,             // Crystal has settled.
  output logic      osc_tick,               // One pulse per crystal cycle.
  output logic      first_regulator_pg_in,  // First output in regulation.
  output logic      second_regulator_pg_in, // Second output in regulation.
  output logic      gpio_in                 // Resolved io pin level.
);
  logic [1:0] ph;
  logic [3:0] settle;
  logic [2:0] ramp1;
  logic [2:0] ramp2;
  // The crystal settles eight clocks after enable and ticks on every fourth clock.
  always_ff @(posedge aclk) begin
    ph <= osc_enable ? ph + 2'h1 : 2'h0;
    settle <= !osc_enable ? 4'h0 : settle + {3'h0, !settle[3]};
    ramp1 <= {ramp1[1:0], first_regulator_en};
    ramp2 <= {ramp2[1:0], second_regulator_en};
  end
  // Outputs ramp for three clocks before a comparator reports regulation.
  assign osc_stable = settle[3];
  assign osc_tick = osc_enable & (ph == 2'h3);
  assign first_regulator_pg_in = first_regulator_en & ramp1[2];
  assign second_regulator_pg_in = second_regulator_en & ramp2[2];
  // An undriven io pin takes the level of the outside device.
  assign gpio_in = gpio_oe ? gpio_out : ext_lvl;
endmodule : cpmu_far_model

//--- tb/tb.sv
`timescale 1ns/1ps
`define CHK(a,b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  import cpmu_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, thermal_event;
  logic [7:0] s_axi_awaddr, s_axi_araddr, led_sink_code;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic first_regulator_pg_in, second_regulator_pg_in, privacy_led_enable_pin, osc_stable;
  logic osc_tick, gpio_in, gpio_out, gpio_oe, general_output_pin_out, general_output_pin_oe;
  logic first_regulator_en, second_regulator_en, first_regulator_dis, second_regulator_dis;
  logic osc_enable, sensor_clock_output_en, led_sink_en, led_pwm, ext_lvl;
  int error_cnt, checks_done, cyc;
  cpmu_top #(.STARTUP_CYCLES(8)) i_dut (.*);
  cpmu_far_model i_far (.*);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // A hang is cut short and counted as an error.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : idle
  // Write one word; each channel is released at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic ta, tw, tv;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(negedge aclk);
      {ta, tw, tv, rr} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tv);
    s_axi_bready <= 1'b0;
    `CHK(rr, 2'h0)
  endtask : wr
  // Read one word and compare its low byte, upper bits must read zero.
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic ta, tv;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(negedge aclk);
      {ta, tv, rv} = {s_axi_arready, s_axi_rvalid, s_axi_rdata};
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tv);
    s_axi_rready <= 1'b0;
    `CHK(rv, {24'h00_0000, e})
  endtask : rchk
  // Reset state, regulator enables, power-good and io pin as second enable.
  task automatic t_reg();
    idle(1);
    `CHK({first_regulator_dis, second_regulator_dis, osc_enable}, 3'b110)
    rchk(8'h04, 8'h00);
    wr(8'h00, 16'h0001);
    idle(6);
    `CHK({first_regulator_en, first_regulator_dis}, 2'b10)
    rchk(8'h00, 8'h05);
    ext_lvl <= 1'b1;
    idle(6);
    `CHK(second_regulator_en, 1'b1)
    rchk(8'h00, 8'h0D);
    @(posedge aclk);
    ext_lvl <= 1'b0;
    idle(3);
    `CHK(second_regulator_en, 1'b0)
  endtask : t_reg
  // Output pin modes, then loss of the first regulator.
  task automatic t_io();
    wr(8'h04, 16'h0001);
    idle(2);
    `CHK({general_output_pin_out, general_output_pin_oe}, 2'b11)
    wr(8'h04, 16'h0003);
    idle(2);
    `CHK(general_output_pin_oe, 1'b0)
    wr(8'h04, 16'h0030);
    idle(2);
    `CHK({gpio_out, gpio_oe}, 2'b01)
    wr(8'h04, 16'h0019);
    idle(2);
    `CHK({gpio_out, gpio_oe}, 2'b11)
    wr(8'h00, 16'h0000);
    idle(2);
    `CHK({gpio_oe, general_output_pin_oe}, 2'b00)
    rchk(8'h04, 8'h11);
  endtask : t_io
  // Thermal event clears both enables and they stay cleared.
  task automatic t_therm();
    wr(8'h00, 16'h0003);
    thermal_event <= 1'b1;
    idle(1);
    thermal_event <= 1'b0;
    idle(8);
    `CHK({first_regulator_en, second_regulator_en}, 2'b00)
    rchk(8'h00, 8'h00);
    rchk(8'h14, 8'h10);
  endtask : t_therm
  // Privacy LED follows its pin only.
  task automatic t_led();
    wr(8'h10, 16'h005A);
    wr(8'h08, 16'h0030);
    idle(2);
    `CHK(led_sink_en, 1'b0)
    privacy_led_enable_pin <= 1'b1;
    idle(3);
    `CHK({led_sink_en, led_sink_code}, 9'h15A)
    `CHK(osc_enable, 1'b1)
    // Keep the oscillator alive so the running dimming period can close.
    wr(8'h08, 16'h0004);
    privacy_led_enable_pin <= 1'b0;
    idle(3);
    `CHK({led_sink_en, led_sink_code}, 9'h000)
    idle(4700);
    rchk(8'h14, 8'h13);
  endtask : t_led
  // Sensor clock start-up delay, restart and first regulator gating.
  task automatic t_clk();
    int n;
    wr(8'h00, 16'h0001);
    wr(8'h08, 16'h0002);
    wr(8'h08, 16'h0006);
    idle(1);
    `CHK({osc_enable, sensor_clock_output_en}, 2'b10)
    n = 0;
    while (!sensor_clock_output_en && n < 400) begin
      idle(1);
      n++;
    end
    `CHK(n > 20 && n < 400, 1'b1)
    wr(8'h08, 16'h0002);
    wr(8'h08, 16'h0006);
    idle(1);
    `CHK(sensor_clock_output_en, 1'b0)
    wr(8'h00, 16'h0000);
    idle(100);
    `CHK({osc_enable, sensor_clock_output_en}, 2'b10)
    wr(8'h08, 16'h0000);
  endtask : t_clk
  // Four dimming periods at the fastest rate with one dither step.
  task automatic t_pwm();
    int n, h;
    wr(8'h08, 16'h0004);
    wr(8'h0C, 16'h0101);
    privacy_led_enable_pin <= 1'b1;
    n = 0;
    while (!led_pwm && n < 9000) begin
      idle(1);
      n++;
    end
    h = 0;
    repeat (16384) begin
      h += int'(led_pwm);
      idle(1);
    end
    `CHK(h, 4112)
    privacy_led_enable_pin <= 1'b0;
    n = 0;
    while (led_pwm && n < 2000) begin
      idle(1);
      n++;
    end
    `CHK(n >= 1024 && n < 2000, 1'b1)
  endtask : t_pwm
  task automatic test_done();
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // Main sequence.
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {thermal_event, privacy_led_enable_pin, ext_lvl} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reg();
    t_io();
    t_therm();
    t_led();
    t_clk();
    t_pwm();
    test_done();
  end
endmodule : tb
